// *** rtl/baud_div_pkg.sv ***
// Purpose: Shared constants for the baud-rate divisor block
// Assumes: 32-bit register port with byte addresses, 100 MHz clock
// Notes:   Divisor is held in units of 1/64 of a clock period
package baud_div_pkg;

  // Widths of the port and of the divisor fields
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int INT_W  = 16;
  localparam int FRAC_W = 6;
  localparam int DIV_W  = INT_W + FRAC_W;
  localparam int ACC_W  = DIV_W + 1;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INT_DIV  = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_FRAC_DIV = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE   = 12'h0f8;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h0fc;

  // Field positions
  localparam int WHOLE_LSB    = 0;
  localparam int FRACTION_LSB = 0;
  localparam int ACT_INT_LSB  = 0;
  localparam int ACT_FRAC_LSB = 16;
  localparam int STAT_PEND    = 0;

  // Values after reset
  localparam logic [INT_W-1:0]  INT_RST  = 16'h0000;
  localparam logic [FRAC_W-1:0] FRAC_RST = 6'h00;
  localparam logic [ACC_W-1:0]  ACC_RST  = 23'h000000;

  // One clock period expressed in 1/64 units
  localparam logic [ACC_W-1:0]  FRAC_STEP = 23'h000040;

  typedef enum logic [0:0] {
    COMMIT_IDLE,
    COMMIT_WAIT
  } commit_state_e;

endpackage : baud_div_pkg

// *** rtl/baud_tick_gen.sv ***
// Purpose: Fractional divider producing the oversampling tick
// Assumes: Divisor inputs change only on the edge that ends a restart_i cycle
// Notes:   Ratio is int + frac/64 clocks per tick; int of zero gives 1
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen
  import baud_div_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  input  wire logic              restart_i,
  input  wire logic [INT_W-1:0]  div_int_i,
  input  wire logic [FRAC_W-1:0] div_frac_i,
  output logic                   tick_o
);

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic             tick_q;
  logic             tick_d;
  logic [ACC_W-1:0] div_full;
  logic [ACC_W-1:0] sum;

  assign div_full = {1'b0, div_int_i, div_frac_i};
  assign sum      = acc_q + FRAC_STEP;

  always_comb begin
    acc_d  = sum;
    tick_d = 1'b0;
    if (div_int_i == INT_RST) begin
      // Smallest ratio: fraction has no say here
      acc_d  = ACC_RST; // R4
      tick_d = 1'b1; // R4
    end else if (restart_i) begin
      acc_d  = ACC_RST;
      tick_d = 1'b0;
    end else if (sum >= div_full) begin
      // Carry the remainder so the fraction averages out
      acc_d  = sum - div_full; // R8
      tick_d = 1'b1; // R8
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      acc_q  <= ACC_RST;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule : baud_tick_gen
`default_nettype wire

// *** rtl/uart_baud_divisor.sv ***
// Purpose: Baud divisor registers with deferred commit to the generator
// Assumes: Line control write and character status come from this clock
// Notes:   Divisor writes are held; only a line control write stages them for commit
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (R1) Integer divisor register, bits 15:0, read and write.
// (R2) Fractional divisor register, bits 5:0, read and write.
// (R3) Reset clears both divisor registers to zero.
// (R4) Integer divisor of zero gives ratio 1 and ignores the fraction.
// (R5) Old divisor stays in use until the current character ends.
// (R6) Software writes line control after changing a divisor.
// (R7) Divisor is latched for the generator only on line control write.
// (R8) Tick period is int plus frac/64 clocks, sixteen ticks per bit.
module uart_baud_divisor
  import baud_div_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              line_ctrl_wr_i,
  input  wire logic              line_busy_i,
  input  wire logic              char_done_i,
  output logic      [INT_W-1:0]  active_int_o,
  output logic      [FRAC_W-1:0] active_frac_o,
  output logic                   commit_pending_o,
  output logic                   baud_tick_o
);

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  // Software-visible divisor registers
  logic [INT_W-1:0]  int_reg_q;
  logic [INT_W-1:0]  int_reg_d;
  logic [FRAC_W-1:0] frac_reg_q;
  logic [FRAC_W-1:0] frac_reg_d;

  // Staged copy taken at the line control write
  logic [INT_W-1:0]  staged_int_q;
  logic [INT_W-1:0]  staged_int_d;
  logic [FRAC_W-1:0] staged_frac_q;
  logic [FRAC_W-1:0] staged_frac_d;

  // Copy the generator runs from
  logic [INT_W-1:0]  active_int_q;
  logic [INT_W-1:0]  active_int_d;
  logic [FRAC_W-1:0] active_frac_q;
  logic [FRAC_W-1:0] active_frac_d;

  commit_state_e     commit_q;
  commit_state_e     commit_d;
  logic              apply_w;

  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  logic              wr_int;
  logic              wr_frac;

  assign wr_int  = wr_i && addr_hit(addr_i, OFS_INT_DIV);
  assign wr_frac = wr_i && addr_hit(addr_i, OFS_FRAC_DIV);

  // Register file
  always_comb begin
    int_reg_d  = int_reg_q;
    frac_reg_d = frac_reg_q;
    if (wr_int) begin
      int_reg_d = wdata_i[WHOLE_LSB +: INT_W]; // R1
    end
    if (wr_frac) begin
      frac_reg_d = wdata_i[FRACTION_LSB +: FRAC_W]; // R2
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      int_reg_q  <= INT_RST; // R3
      frac_reg_q <= FRAC_RST; // R3
    end else begin
      int_reg_q  <= int_reg_d;
      frac_reg_q <= frac_reg_d;
    end
  end

  // Commit path: stage on line control write, switch at a character edge.
  // An idle line counts as a boundary so a quiet port picks it up at once.
  assign apply_w = (commit_q == COMMIT_WAIT) && (char_done_i || !line_busy_i); // R5

  always_comb begin
    commit_d      = commit_q;
    staged_int_d  = staged_int_q;
    staged_frac_d = staged_frac_q;
    active_int_d  = active_int_q;
    active_frac_d = active_frac_q;
    case (commit_q)
      COMMIT_IDLE: begin
        commit_d = COMMIT_IDLE;
      end
      COMMIT_WAIT: begin
        if (apply_w) begin
          active_int_d  = staged_int_q; // R5
          active_frac_d = staged_frac_q; // R5
          commit_d      = COMMIT_IDLE;
        end
      end
      default: begin
        commit_d = COMMIT_IDLE;
      end
    endcase
    // A line control write beside an apply wins, so it is not lost
    if (line_ctrl_wr_i) begin
      staged_int_d  = int_reg_q; // R7
      staged_frac_d = frac_reg_q; // R7
      commit_d      = COMMIT_WAIT; // R7
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      commit_q      <= COMMIT_IDLE;
      staged_int_q  <= INT_RST;
      staged_frac_q <= FRAC_RST;
      active_int_q  <= INT_RST;
      active_frac_q <= FRAC_RST;
    end else begin
      commit_q      <= commit_d;
      staged_int_q  <= staged_int_d;
      staged_frac_q <= staged_frac_d;
      active_int_q  <= active_int_d;
      active_frac_q <= active_frac_d;
    end
  end

  // Read port: data valid only the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      if (addr_hit(addr_i, OFS_INT_DIV)) begin
        rdata_d[WHOLE_LSB +: INT_W] = int_reg_q; // R1
      end else if (addr_hit(addr_i, OFS_FRAC_DIV)) begin
        rdata_d[FRACTION_LSB +: FRAC_W] = frac_reg_q; // R2
      end else if (addr_hit(addr_i, OFS_ACTIVE)) begin
        rdata_d[ACT_INT_LSB +: INT_W]   = active_int_q;
        rdata_d[ACT_FRAC_LSB +: FRAC_W] = active_frac_q;
      end else if (addr_hit(addr_i, OFS_STATUS)) begin
        rdata_d[STAT_PEND] = (commit_q == COMMIT_WAIT);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Restart on apply so the old phase does not leak into the new rate
  baud_tick_gen u_tick_gen (
    .clock_i    (clock_i),
    .srst_i     (srst_i),
    .restart_i  (apply_w),
    .div_int_i  (active_int_q),
    .div_frac_i (active_frac_q),
    .tick_o     (baud_tick_o)
  );

  assign rdata_o          = rdata_q;
  assign active_int_o     = active_int_q;
  assign active_frac_o    = active_frac_q;
  assign commit_pending_o = (commit_q == COMMIT_WAIT);

  // Checks

  a_reset_clear: assert property ( // R3
    @(posedge clock_i) srst_i |=> (int_reg_q == INT_RST) && (frac_reg_q == FRAC_RST)
                                 && (active_int_q == INT_RST))
    else $error("divisor registers not cleared by reset");

  a_int_write: assert property ( // R1
    @(posedge clock_i) disable iff (srst_i)
    wr_i && (addr_i == OFS_INT_DIV)
      |=> int_reg_q == $past(wdata_i[15:0]))
    else $error("integer divisor write not stored");

  a_frac_write: assert property ( // R2
    @(posedge clock_i) disable iff (srst_i)
    wr_i && (addr_i == OFS_FRAC_DIV)
      |=> frac_reg_q == $past(wdata_i[5:0]))
    else $error("fractional divisor write not stored");

  a_int_readback: assert property ( // R1
    @(posedge clock_i) disable iff (srst_i)
    rd_i && (addr_i == OFS_INT_DIV)
      |=> rdata_o == {16'h0000, $past(int_reg_q)})
    else $error("integer divisor readback wrong");

  a_frac_readback: assert property ( // R2
    @(posedge clock_i) disable iff (srst_i)
    rd_i && (addr_i == OFS_FRAC_DIV)
      |=> rdata_o == {26'h0000000, $past(frac_reg_q)})
    else $error("fractional divisor readback wrong");

  // Reset leaves the tick low at the release edge, so start after it
  a_min_ratio: assert property ( // R4
    @(posedge clock_i) disable iff (srst_i)
    !srst_i && (active_int_q == 16'h0000) ##1 (active_int_q == 16'h0000) |-> baud_tick_o)
    else $error("zero integer divisor must tick every cycle");

  a_hold_no_commit: assert property ( // R7
    @(posedge clock_i) disable iff (srst_i)
    !apply_w |=> $stable(active_int_q) && $stable(active_frac_q))
    else $error("active divisor changed without a commit");

  a_hold_mid_char: assert property ( // R5
    @(posedge clock_i) disable iff (srst_i)
    line_busy_i && !char_done_i |=> $stable(active_int_q) && $stable(active_frac_q))
    else $error("active divisor changed inside a character");

  a_stage_on_lcr: assert property ( // R7
    @(posedge clock_i) disable iff (srst_i)
    line_ctrl_wr_i |=> commit_pending_o
                       && (staged_int_q == $past(int_reg_q))
                       && (staged_frac_q == $past(frac_reg_q)))
    else $error("line control write did not stage the divisor");

  a_commit_idle: assert property ( // R5
    @(posedge clock_i) disable iff (srst_i)
    commit_pending_o && !line_busy_i && !line_ctrl_wr_i
      |=> !commit_pending_o && (active_int_q == $past(staged_int_q))
          && (active_frac_q == $past(staged_frac_q)))
    else $error("staged divisor not applied on idle line");

  a_tick_period: assert property ( // R8
    @(posedge clock_i) disable iff (srst_i)
    baud_tick_o && !apply_w && (active_int_q == 16'h0002)
      && (active_frac_q == 6'h00) ##1 !apply_w
      |-> !baud_tick_o ##1 baud_tick_o)
    else $error("divide by two tick spacing wrong");

  // Register port and commit bookkeeping
  a_rdata_idle: assert property ( // R1
    @(posedge clock_i) disable iff (srst_i)
    !rd_i |=> rdata_o == '0)
    else $error("read data not cleared after the read cycle");

  a_other_write: assert property ( // R1
    @(posedge clock_i) disable iff (srst_i)
    wr_i && (addr_i != OFS_INT_DIV) && (addr_i != OFS_FRAC_DIV)
      |=> $stable(int_reg_q) && $stable(frac_reg_q))
    else $error("write to another address changed a divisor");

  a_status_read: assert property ( // R5
    @(posedge clock_i) disable iff (srst_i)
    rd_i && (addr_i == OFS_STATUS)
      |=> rdata_o == {31'h0, $past(commit_pending_o)})
    else $error("status readback wrong");

  a_active_read: assert property ( // R7
    @(posedge clock_i) disable iff (srst_i)
    rd_i && (addr_i == OFS_ACTIVE)
      |=> rdata_o == {10'h0, $past(active_frac_q), $past(active_int_q)})
    else $error("active divisor view wrong");

  a_pending_holds: assert property ( // R5
    @(posedge clock_i) disable iff (srst_i)
    commit_pending_o && line_busy_i && !char_done_i |=> commit_pending_o)
    else $error("pending divisor dropped inside a character");

  a_reset_quiet: assert property ( // R3
    @(posedge clock_i) srst_i |=> !commit_pending_o && !baud_tick_o && (rdata_o == '0))
    else $error("control state not cleared by reset");

  a_restart_quiet: assert property ( // R8
    @(posedge clock_i) disable iff (srst_i)
    apply_w && (active_int_q != 16'h0000) |=> !baud_tick_o)
    else $error("tick issued in the cycle of a divisor switch");

  c_commit_at_char_end: cover property (
    @(posedge clock_i) disable iff (srst_i)
    commit_pending_o && line_busy_i ##1 commit_pending_o && char_done_i
      ##1 !commit_pending_o);

  c_stage_while_apply: cover property (
    @(posedge clock_i) disable iff (srst_i)
    apply_w && line_ctrl_wr_i);

  c_frac_tick: cover property (
    @(posedge clock_i) disable iff (srst_i)
    baud_tick_o && (active_frac_q != 6'h00) && (active_int_q != 16'h0000));

  c_write_then_lcr: cover property (
    @(posedge clock_i) disable iff (srst_i)
    wr_i && (addr_i == OFS_INT_DIV) ##[1:8] line_ctrl_wr_i);

endmodule : uart_baud_divisor
`default_nettype wire

// *** testbench/uart_baud_divisor_test.sv ***
// Purpose: Self-checking bench for the baud divisor registers and commit path
// Assumes: Register port answers reads one cycle after the strobe
// Notes:   Table rows cover plain register access; commit and tick cases follow
`timescale 1ns/1ps
`default_nettype none
module uart_baud_divisor_test
  import baud_div_pkg::*;
;
  logic              clock_i;
  logic              srst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic              line_ctrl_wr_i;
  logic              line_busy_i;
  logic              char_done_i;
  logic [INT_W-1:0]  active_int_o;
  logic [FRAC_W-1:0] active_frac_o;
  logic              commit_pending_o;
  logic              baud_tick_o;
  int                fail_count;
  int                checks;
  logic [DATA_W-1:0] got;
  int                ticks;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rexp;
  } row_s;

  // Upper bits dropped, unmapped and read-only places read back zero
  row_s rows [6] = '{
    '{12'h024, 32'h0000_1234, 32'h0000_1234},
    '{12'h024, 32'hffff_ffff, 32'h0000_ffff},
    '{12'h028, 32'hffff_ffff, 32'h0000_003f},
    '{12'h028, 32'h0000_0015, 32'h0000_0015},
    '{12'h030, 32'h0000_00aa, 32'h0000_0000},
    '{12'h0fc, 32'h0000_0001, 32'h0000_0000}
  };

  uart_baud_divisor uart_baud_divisor_i (
    .clock_i          (clock_i),
    .srst_i           (srst_i),
    .addr_i           (addr_i),
    .wdata_i          (wdata_i),
    .wr_i             (wr_i),
    .rd_i             (rd_i),
    .rdata_o          (rdata_o),
    .line_ctrl_wr_i   (line_ctrl_wr_i),
    .line_busy_i      (line_busy_i),
    .char_done_i      (char_done_i),
    .active_int_o     (active_int_o),
    .active_frac_o    (active_frac_o),
    .commit_pending_o (commit_pending_o),
    .baud_tick_o      (baud_tick_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task end_of_test();
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task chk_word(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] seen);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_word

  task chk_bit(input string what, input logic exp, input logic seen);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk_bit

  task bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : bus_write

  // Read data stand only in the cycle after the strobe
  task bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : bus_read

  task pulse_line_ctrl();
    @(posedge clock_i);
    line_ctrl_wr_i <= 1'b1;
    @(posedge clock_i);
    line_ctrl_wr_i <= 1'b0;
  endtask : pulse_line_ctrl

  // Always lets one edge pass, so a strobe from this time step is seen
  task wait_apply();
    int i;
    i = 0;
    do begin
      @(posedge clock_i);
      #1;
      i++;
    end while (commit_pending_o !== 1'b0 && i < 20);
    if (commit_pending_o !== 1'b0) begin
      fail_count++;
      $display("BAD commit_wait expected 0 seen %b", commit_pending_o);
      end_of_test();
    end
  endtask : wait_apply

  // Whole periods of the ratio give a count free of phase
  task tick_count(input int cycles, output int n);
    n = 0;
    repeat (cycles) begin
      @(posedge clock_i);
      #1;
      if (baud_tick_o === 1'b1) n++;
    end
  endtask : tick_count

  task do_reset(input int cycles);
    srst_i <= 1'b1;
    repeat (cycles) @(posedge clock_i);
    srst_i <= 1'b0;
    bus_read(OFS_INT_DIV, got);
    chk_word("int_after_reset", 32'h0, got);
    bus_read(OFS_FRAC_DIV, got);
    chk_word("frac_after_reset", 32'h0, got);
    chk_word("active_int", 32'h0, 32'(active_int_o));
    chk_word("active_frac", 32'h0, 32'(active_frac_o));
    chk_bit("pending", 1'b0, commit_pending_o);
  endtask : do_reset

  initial begin
    fail_count = 0;
    checks = 0;
    srst_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    line_ctrl_wr_i = 1'b0;
    line_busy_i = 1'b0;
    char_done_i = 1'b0;
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    bus_read(OFS_INT_DIV, got);
    chk_word("int_after_reset", 32'h0, got);
    for (int k = 0; k < 6; k++) begin
      bus_write(rows[k].addr, rows[k].wdata);
      bus_read(rows[k].addr, got);
      chk_word("reg_read", rows[k].rexp, got);
    end
    // Divisor writes alone must not reach the generator
    chk_word("active_int", 32'h0, 32'(active_int_o));
    chk_bit("pending", 1'b0, commit_pending_o);
    tick_count(8, ticks);
    chk_word("ticks_div0", 32'd8, 32'(ticks));
    // Busy line: commit waits for the character to end
    @(posedge clock_i);
    line_busy_i <= 1'b1;
    bus_write(OFS_INT_DIV, 32'h0000_0002);
    bus_write(OFS_FRAC_DIV, 32'h0000_0000);
    pulse_line_ctrl();
    repeat (5) @(posedge clock_i);
    #1;
    chk_bit("pending", 1'b1, commit_pending_o);
    chk_word("active_int", 32'h0, 32'(active_int_o));
    bus_read(OFS_STATUS, got);
    chk_word("status", 32'h0000_0001, got);
    @(posedge clock_i);
    char_done_i <= 1'b1;
    @(posedge clock_i);
    char_done_i <= 1'b0;
    wait_apply();
    chk_word("active_int", 32'h2, 32'(active_int_o));
    bus_read(OFS_ACTIVE, got);
    chk_word("active_view", 32'h0000_0002, got);
    tick_count(8, ticks);
    chk_word("ticks_div2", 32'd4, 32'(ticks));
    // Idle line: zero integer part ignores the fraction
    @(posedge clock_i);
    line_busy_i <= 1'b0;
    bus_write(OFS_INT_DIV, 32'h0000_0000);
    bus_write(OFS_FRAC_DIV, 32'h0000_0015);
    pulse_line_ctrl();
    wait_apply();
    chk_word("active_frac", 32'h15, 32'(active_frac_o));
    tick_count(8, ticks);
    chk_word("ticks_div0_frac", 32'd8, 32'(ticks));
    // Commit and new line control write in one cycle: old lands, new waits
    @(posedge clock_i);
    line_busy_i <= 1'b1;
    bus_write(OFS_INT_DIV, 32'h0000_0003);
    pulse_line_ctrl();
    bus_write(OFS_INT_DIV, 32'h0000_0001);
    bus_write(OFS_FRAC_DIV, 32'h0000_0020);
    @(posedge clock_i);
    char_done_i    <= 1'b1;
    line_ctrl_wr_i <= 1'b1;
    @(posedge clock_i);
    char_done_i    <= 1'b0;
    line_ctrl_wr_i <= 1'b0;
    #1;
    chk_word("active_int", 32'h3, 32'(active_int_o));
    chk_bit("pending", 1'b1, commit_pending_o);
    @(posedge clock_i);
    line_busy_i <= 1'b0;
    wait_apply();
    chk_word("active_int", 32'h1, 32'(active_int_o));
    chk_word("active_frac", 32'h20, 32'(active_frac_o));
    // Ratio 1.5: two ticks in every three cycles
    tick_count(6, ticks);
    chk_word("ticks_frac", 32'd4, 32'(ticks));
    // Reset again in mid-run
    @(posedge clock_i);
    do_reset(2);
    end_of_test();
  end
endmodule : uart_baud_divisor_test
`default_nettype wire
